// >>> core/pps_consts.svh
// constants for the port and pin-sharing block
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH
`define PPS_PORT_W       8
`define PPS_NIB_W        4
`define PPS_DIR_RST      8'h00
`define PPS_LAT_RST      8'h00
`define PPS_MODE_SELECT_A_CE_BIT  6
`define PPS_MODE_SELECT_A_OE_BIT  7
// refresh pulse period and width, in system clocks
`define PPS_PSRAM_REFRESH_PULSE_PERIOD  8'h40
`define PPS_PSRAM_REFRESH_PULSE_WIDTH   8'h01
`endif

// >>> core/pps_pkg.sv
// types for the port and pin-sharing block
package pps_pkg;
  typedef logic [7:0] pps_byte_type;
  typedef enum logic [2:0] {
    PPS_IDLE = 3'b001,
    PPS_ADDR = 3'b010,
    PPS_DATA = 3'b100
  } pps_bus_type;
endpackage

// >>> core/pps_port_pin_sharing.sv
// port pins, direction control, alternate functions and bus sharing
`timescale 1ns/1ps
`include "pps_consts.svh"
// Operation
// - port a: eight bits, each bit individually input or output
// - port a nibbles act as two independent four-bit real-time outputs
// - port c low nibble input only, upper bits individually directed
// - port d low nibble input only, upper bits individually directed
// - port e switches direction only as a whole byte
// - port f: eight bits, each bit individually input or output
// - expanded memory puts muxed low address and data on port e
// - an address-latch strobe is driven during each external access
// - external fetch select low means rom-less external fetch
// - asynchronous serial: handshake pin is transmit-enable input
// - synchronous serial: handshake pin carries serial clock in or out
// - a refresh pulse is driven for attached pseudo-static memory
// - prom mode: port a bit 6 chip-enable, bit 7 output-enable
// - prom mode: reset pin selects programming mode instead of reset
module pps_port_pin_sharing (
  input  wire logic              i_mclk,          // system clock
  input  wire logic              i_rst,           // sync reset, high
  input  wire pps_pkg::pps_byte_type i_pa_dir,    // port a dir, 1=out
  input  wire pps_pkg::pps_byte_type i_pa_lat,    // port a latch
  input  wire logic [1:0]        i_pa_rt_en,      // real-time nibble mode
  input  wire logic [1:0]        i_pa_rt_trig,    // nibble update strobes
  input  wire pps_pkg::pps_byte_type i_pa_rt_data,// real-time buffer
  input  wire pps_pkg::pps_byte_type i_pb_dir,    // port b dir
  input  wire pps_pkg::pps_byte_type i_pb_lat,    // port b latch
  input  wire pps_pkg::pps_byte_type i_pc_dir,    // port c dir
  input  wire pps_pkg::pps_byte_type i_pc_lat,    // port c latch
  input  wire pps_pkg::pps_byte_type i_pd_dir,    // port d dir
  input  wire pps_pkg::pps_byte_type i_pd_lat,    // port d latch
  input  wire logic              i_pe_dir,        // port e byte dir
  input  wire pps_pkg::pps_byte_type i_pe_lat,    // port e latch
  input  wire pps_pkg::pps_byte_type i_pf_dir,    // port f dir
  input  wire pps_pkg::pps_byte_type i_pf_lat,    // port f latch
  input  wire logic              i_mem_exp_en,    // memory expansion on
  input  wire logic              i_acc_req,       // start external access
  input  wire logic              i_acc_wr,        // access is a write
  input  wire logic [15:0]       i_acc_addr,      // access address
  input  wire pps_pkg::pps_byte_type i_acc_wdata, // write data
  input  wire logic              i_ser_en,        // serial unit on
  input  wire logic              i_ser_sync,      // 1=sync i/o mode
  input  wire logic              i_ser_clk_out,   // 1=drive serial clock
  input  wire logic              i_ser_clk,       // internal serial clock
  input  wire logic              i_ser_txd,       // serial tx data
  input  wire logic              i_pwm_en,        // pwm outputs on
  input  wire logic [1:0]        i_pwm,           // pwm levels
  input  wire logic              i_psram_refresh_pulse_en,       // refresh enable
  input  wire pps_pkg::pps_byte_type i_port_a_bits,  // port a pins in
  input  wire pps_pkg::pps_byte_type i_port_b_bits,  // port b pins in
  input  wire pps_pkg::pps_byte_type i_port_c_bits,  // port c pins in
  input  wire pps_pkg::pps_byte_type i_port_d_bits,  // port d pins in
  input  wire pps_pkg::pps_byte_type i_port_e_bits,  // port e pins in
  input  wire pps_pkg::pps_byte_type i_port_f_bits,  // port f pins in
  input  wire logic              i_external_fetch_select, // pin level
  input  wire logic              i_mode_select_a, // reset/mode_select_a pin level
  output logic [7:0]             o_port_a_bits,   // port a out
  output logic [7:0]             o_port_a_oe,     // port a enable
  output logic [7:0]             o_port_b_bits,   // port b out
  output logic [7:0]             o_port_b_oe,     // port b enable
  output logic [7:0]             o_port_c_bits,   // port c out
  output logic [7:0]             o_port_c_oe,     // port c enable
  output logic [7:0]             o_port_d_bits,   // port d out
  output logic [7:0]             o_port_d_oe,     // port d enable
  output logic [7:0]             o_port_e_bits,   // port e / mux bus out
  output logic [7:0]             o_port_e_oe,     // port e enable
  output logic [7:0]             o_port_f_bits,   // port f / high addr
  output logic [7:0]             o_port_f_oe,     // port f enable
  output logic [7:0]             o_pin_a,         // synced port a in
  output logic [7:0]             o_pin_b,         // synced port b in
  output logic [7:0]             o_pin_c,         // synced port c in
  output logic [7:0]             o_pin_d,         // synced port d in
  output logic [7:0]             o_pin_e,         // synced port e in
  output logic [7:0]             o_pin_f,         // synced port f in
  output logic                   o_addr_latch,    // address latch strobe
  output logic                   o_acc_done,      // access done pulse
  output logic [7:0]             o_acc_rdata,     // read data
  output logic                   o_psram_refresh_pulse, // refresh pin
  output logic                   o_rom_less,      // external fetch mode
  output logic                   o_prom_mode,     // programming mode
  output logic                   o_prom_ce_n,     // prom chip enable
  output logic                   o_prom_oe_n,     // prom output enable
  output logic                   o_sys_rst,       // gated system reset
  output logic                   o_tx_enable,     // async tx gate
  output logic                   o_ser_clk_in     // sync serial clk in
);
  import pps_pkg::*;

  typedef struct packed {
    logic [5:0][7:0] s1;
    logic [5:0][7:0] s2;
    logic [1:0]      m1;
    logic [1:0]      m2;
    logic [1:0]      fcnt;
    logic [1:0]      dcnt;
    logic [7:0]      rt;
    pps_bus_type     bus;
    logic            ale;
    logic            done;
    logic [7:0]      rdata;
    logic [7:0]      rcnt;
    logic            psram_refresh_pulse;
    logic            rom_less;
    logic            fetch_cap;
    logic [47:0]     pout;
    logic [47:0]     poe;
    logic            prom;
    logic            ce_n;
    logic            oe_n;
    logic            srst;
    logic            txen;
    logic            sclk;
  } pps_state_type;

  pps_state_type st_reg;
  pps_state_type st_next;

  // per-bit pin mux: alternate drives only when its enable is set
  function automatic logic [1:0] pin_mux(input logic dir, input logic lat,
                                         input logic alt_en,
                                         input logic alt_oe,
                                         input logic alt_v);
    pin_mux = alt_en ? {alt_oe, alt_v} : {dir, lat};
  endfunction

  always_comb begin
    logic [7:0] a_out;
    logic [7:0] c_oe;
    logic [7:0] d_oe;
    logic [1:0] m;
    st_next = st_reg;
    a_out = 8'h00;
    c_oe = 8'h00;
    d_oe = 8'h00;
    m = 2'b00;
    // two-stage sync of every pin input; stage one feeds stage two only
    st_next.s1 = {i_port_f_bits, i_port_e_bits, i_port_d_bits,
                  i_port_c_bits, i_port_b_bits, i_port_a_bits};
    st_next.s2 = st_reg.s1;
    st_next.m1 = {i_mode_select_a, i_external_fetch_select};
    st_next.m2 = st_reg.m1;
    // fetch select caught once, on the third edge after reset release,
    // when the sync stages hold the real pin level; held steady after
    if (!st_reg.fetch_cap) begin
      if (st_reg.fcnt == 2'h2) begin
        st_next.rom_less = ~st_reg.m2[0];
        st_next.fetch_cap = 1'b1;
      end else begin
        st_next.fcnt = st_reg.fcnt + 2'h1;
      end
    end
    // programming-mode select replaces reset while it is high
    st_next.prom = st_reg.m2[1];
    st_next.srst = ~st_reg.m2[1] & i_rst;
    st_next.ce_n = st_reg.s2[0][`PPS_MODE_SELECT_A_CE_BIT];
    st_next.oe_n = st_reg.s2[0][`PPS_MODE_SELECT_A_OE_BIT];
    // real-time nibbles load independently on their own trigger
    if (i_pa_rt_trig[0])
      st_next.rt[3:0] = i_pa_rt_data[3:0];
    if (i_pa_rt_trig[1])
      st_next.rt[7:4] = i_pa_rt_data[7:4];
    a_out[3:0] = i_pa_rt_en[0] ? st_reg.rt[3:0] : i_pa_lat[3:0];
    a_out[7:4] = i_pa_rt_en[1] ? st_reg.rt[7:4] : i_pa_lat[7:4];
    // port a: per-bit dir; inputs only while programming
    st_next.pout[7:0] = a_out;
    st_next.poe[7:0] = st_reg.prom ? 8'h00 : i_pa_dir;
    st_next.pout[15:8] = i_pb_lat;
    st_next.poe[15:8] = i_pb_dir;
    // port c: low nibble input only; bits 4..7 carry serial functions
    c_oe = {i_pc_dir[7:4], 4'h0};
    st_next.pout[23:16] = i_pc_lat;
    m = pin_mux(c_oe[4], i_pc_lat[4], i_ser_en, 1'b1, i_ser_txd);
    {c_oe[4], st_next.pout[20]} = m;
    m = pin_mux(c_oe[5], i_pc_lat[5], i_ser_en, 1'b0, 1'b0);
    {c_oe[5], st_next.pout[21]} = m;
    m = pin_mux(c_oe[6], i_pc_lat[6], i_ser_en, 1'b1, i_ser_clk);
    {c_oe[6], st_next.pout[22]} = m;
    // handshake pin: tx gate in async, serial clock in sync mode
    m = pin_mux(c_oe[7], i_pc_lat[7], i_ser_en,
                i_ser_sync & i_ser_clk_out, i_ser_clk);
    {c_oe[7], st_next.pout[23]} = m;
    st_next.poe[23:16] = c_oe;
    st_next.txen = ~i_ser_en | i_ser_sync | st_reg.s2[2][7];
    st_next.sclk = st_reg.s2[2][7];   // pin level, not internal
    // port d: low nibble input only; pwm on bits 4 and 5
    d_oe = {i_pd_dir[7:4], 4'h0};
    st_next.pout[31:24] = i_pd_lat;
    for (int k = 0; k < 2; k++) begin
      m = pin_mux(d_oe[4+k], i_pd_lat[4+k], i_pwm_en, 1'b1, i_pwm[k]);
      {d_oe[4+k], st_next.pout[28+k]} = m;
    end
    st_next.poe[31:24] = d_oe;
    // port e whole-byte dir, port f per bit, unless bus takes them
    st_next.pout[39:32] = i_pe_lat;
    st_next.poe[39:32] = {8{i_pe_dir}};
    st_next.pout[47:40] = i_pf_lat;
    st_next.poe[47:40] = i_pf_dir;
    // external access: address phase with strobe, then data phase
    st_next.ale = 1'b0;
    st_next.done = 1'b0;
    unique case (st_reg.bus)
      PPS_IDLE: begin
        if (i_mem_exp_en && i_acc_req) begin
          st_next.bus = PPS_ADDR;
          st_next.ale = 1'b1;
        end
      end
      PPS_ADDR: st_next.bus = PPS_DATA;
      PPS_DATA: begin
        // two extra cycles let the read byte clear the pin sync
        if (st_reg.dcnt == 2'h2) begin
          st_next.bus = PPS_IDLE;
          st_next.done = 1'b1;
          st_next.rdata = st_reg.s2[4];
          st_next.dcnt = 2'h0;
        end else begin
          st_next.dcnt = st_reg.dcnt + 2'h1;
        end
      end
    endcase
    if (i_mem_exp_en) begin
      st_next.poe[47:40] = 8'hff;
      st_next.pout[47:40] = i_acc_addr[15:8];
      st_next.poe[39:32] = (st_next.bus == PPS_ADDR) ? 8'hff :
                           (st_next.bus == PPS_DATA && i_acc_wr) ?
                           8'hff : 8'h00;
      st_next.pout[39:32] = (st_next.bus == PPS_DATA) ? i_acc_wdata :
                            i_acc_addr[7:0];
    end
    // refresh pulse: free-running period while enabled
    st_next.rcnt = (st_reg.rcnt == `PPS_PSRAM_REFRESH_PULSE_PERIOD - 8'h01) ? 8'h00 :
                   st_reg.rcnt + 8'h01;
    st_next.psram_refresh_pulse = i_psram_refresh_pulse_en && (st_reg.rcnt < `PPS_PSRAM_REFRESH_PULSE_WIDTH);
  end

  // single state register; reset ignored while programming mode holds
  always_ff @(posedge i_mclk) begin
    if (i_rst && !st_reg.prom) begin
      st_reg <= '0;
      st_reg.bus <= PPS_IDLE;
      st_reg.ce_n <= 1'b1;
      st_reg.oe_n <= 1'b1;
      st_reg.txen <= 1'b1;
      st_reg.srst <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_port_a_bits = st_reg.pout[7:0];
  assign o_port_a_oe = st_reg.poe[7:0];
  assign o_port_b_bits = st_reg.pout[15:8];
  assign o_port_b_oe = st_reg.poe[15:8];
  assign o_port_c_bits = st_reg.pout[23:16];
  assign o_port_c_oe = st_reg.poe[23:16];
  assign o_port_d_bits = st_reg.pout[31:24];
  assign o_port_d_oe = st_reg.poe[31:24];
  assign o_port_e_bits = st_reg.pout[39:32];
  assign o_port_e_oe = st_reg.poe[39:32];
  assign o_port_f_bits = st_reg.pout[47:40];
  assign o_port_f_oe = st_reg.poe[47:40];
  assign o_pin_a = st_reg.s2[0];
  assign o_pin_b = st_reg.s2[1];
  assign o_pin_c = st_reg.s2[2];
  assign o_pin_d = st_reg.s2[3];
  assign o_pin_e = st_reg.s2[4];
  assign o_pin_f = st_reg.s2[5];
  assign o_addr_latch = st_reg.ale;
  assign o_acc_done = st_reg.done;
  assign o_acc_rdata = st_reg.rdata;
  assign o_psram_refresh_pulse = st_reg.psram_refresh_pulse;
  assign o_rom_less = st_reg.rom_less;
  assign o_prom_mode = st_reg.prom;
  assign o_prom_ce_n = st_reg.ce_n;
  assign o_prom_oe_n = st_reg.oe_n;
  assign o_sys_rst = st_reg.srst;
  assign o_tx_enable = st_reg.txen;
  assign o_ser_clk_in = st_reg.sclk;
endmodule

// >>> testbench/pps_props.sv
// concurrent checks on the port and pin-sharing block
`timescale 1ns/1ps
module pps_props (
  input wire logic                  i_mclk,      // system clock
  input wire logic                  i_rst,       // sync reset
  input wire pps_pkg::pps_byte_type i_pa_dir,    // port a dir
  input wire logic [1:0]            i_pa_rt_en,  // real-time mode
  input wire logic [7:0]            o_port_a_oe, // port a enable
  input wire logic [7:0]            o_port_c_oe, // port c enable
  input wire logic [7:0]            o_port_d_oe, // port d enable
  input wire logic [7:0]            o_port_e_oe, // port e enable
  input wire logic                  o_addr_latch, // latch strobe
  input wire logic                  o_acc_done,   // access done
  input wire logic                  o_psram_refresh_pulse, // refresh
  input wire logic                  o_prom_mode   // programming mode
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // direction follows software one cycle later, outside special modes
  pa_dir_follow_a: assert property (
    !o_prom_mode && !$past(o_prom_mode) && !$past(i_rst)
    && $past(i_pa_rt_en) == 2'b00 |-> o_port_a_oe == $past(i_pa_dir))
    else $error("port a enable not following direction");
  pc_low_in_a: assert property (o_port_c_oe[3:0] == 4'h0)
    else $error("port c low nibble driven");
  pd_low_in_a: assert property (o_port_d_oe[3:0] == 4'h0)
    else $error("port d low nibble driven");
  pe_whole_byte_a: assert property (
    o_port_e_oe == 8'h00 || o_port_e_oe == 8'hff)
    else $error("port e enable split");
  ale_bus_drive_a: assert property (
    o_addr_latch |-> o_port_e_oe == 8'hff)
    else $error("address not driven with strobe");
  ale_to_done_a: assert property (o_addr_latch |-> ##4 o_acc_done)
    else $error("done not four cycles after strobe");
  done_has_ale_a: assert property (
    o_acc_done |-> $past(o_addr_latch, 4))
    else $error("done without strobe");
  refresh_width_a: assert property (
    o_psram_refresh_pulse |=> !o_psram_refresh_pulse [*8])
    else $error("refresh pulse too wide or too close");
  prom_port_in_a: assert property (
    o_prom_mode && $past(o_prom_mode) |-> o_port_a_oe == 8'h00)
    else $error("port a driven in programming mode");
  // main scenarios reached
  cover property (o_addr_latch);
  cover property (o_psram_refresh_pulse);
  cover property (o_prom_mode);
endmodule
bind pps_port_pin_sharing pps_props u_props (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_pa_dir(i_pa_dir),
  .i_pa_rt_en(i_pa_rt_en), .o_port_a_oe(o_port_a_oe),
  .o_port_c_oe(o_port_c_oe), .o_port_d_oe(o_port_d_oe),
  .o_port_e_oe(o_port_e_oe), .o_addr_latch(o_addr_latch),
  .o_acc_done(o_acc_done), .o_prom_mode(o_prom_mode),
  .o_psram_refresh_pulse(o_psram_refresh_pulse)
);

// >>> testbench/pps_ext_mem.sv
// external memory model on the multiplexed low address and data bus
`timescale 1ns/1ps
module pps_ext_mem (
  input  wire logic       i_clk, // system clock
  input  wire logic [7:0] i_bus, // device side of the bus
  input  wire logic       i_ale, // address latch strobe
  output logic [7:0]      o_bus  // memory read data
);
  logic [7:0] addr_reg = 8'h00;
  // capture the low address on the strobe, as an external latch would
  always_ff @(posedge i_clk) begin
    if (i_ale) begin
      addr_reg <= i_bus;
    end
  end
  // inverted address as data, so a stale bus value never matches
  assign o_bus = ~addr_reg;
endmodule

// >>> testbench/tb_top.sv
// directed testbench for the port and pin-sharing block
`timescale 1ns/1ps
module tb_top;
  import pps_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  pps_byte_type i_pa_dir, i_pa_lat, i_pa_rt_data, i_pb_dir, i_pb_lat;
  pps_byte_type i_pc_dir, i_pc_lat, i_pd_dir, i_pd_lat, i_pe_lat;
  pps_byte_type i_pf_dir, i_pf_lat, i_acc_wdata, i_port_a_bits;
  pps_byte_type i_port_b_bits, i_port_c_bits, i_port_d_bits, i_port_f_bits;
  pps_byte_type i_port_e_bits, mem_bus;
  logic [1:0] i_pa_rt_en, i_pa_rt_trig, i_pwm;
  logic [15:0] i_acc_addr;
  logic i_pe_dir, i_mem_exp_en, i_acc_req, i_acc_wr, i_ser_en, i_ser_sync;
  logic i_ser_clk_out, i_ser_clk, i_ser_txd, i_pwm_en, i_psram_refresh_pulse_en;
  logic i_external_fetch_select, i_mode_select_a;
  logic [7:0] o_port_a_bits, o_port_a_oe, o_port_b_bits, o_port_b_oe;
  logic [7:0] o_port_c_bits, o_port_c_oe, o_port_d_bits, o_port_d_oe;
  logic [7:0] o_port_e_bits, o_port_e_oe, o_port_f_bits, o_port_f_oe;
  logic [7:0] o_pin_a, o_pin_b, o_pin_c, o_pin_d, o_pin_e, o_pin_f;
  logic [7:0] o_acc_rdata;
  logic o_addr_latch, o_acc_done, o_psram_refresh_pulse, o_rom_less;
  logic o_prom_mode, o_prom_ce_n, o_prom_oe_n, o_sys_rst, o_tx_enable;
  logic o_ser_clk_in;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  // resolved bus level: device where it drives, memory elsewhere
  assign i_port_e_bits = (o_port_e_oe & o_port_e_bits)
                       | (~o_port_e_oe & mem_bus);
  pps_port_pin_sharing dut (.*);
  pps_ext_mem mem (.i_clk(i_mclk), .i_bus(o_port_e_bits),
                   .i_ale(o_addr_latch), .o_bus(mem_bus));
  always #25 i_mclk = ~i_mclk;
  task automatic w(input int k);
    repeat (k) @(posedge i_mclk);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one external access, phases checked cycle by cycle
  task automatic acc(input logic wr, input logic [15:0] a);
    i_acc_req <= 1'b1;
    i_acc_wr <= wr;
    i_acc_addr <= a;
    w(1);
    i_acc_req <= 1'b0;
    #1 chk(o_addr_latch, 16'h1);
    chk(o_port_e_bits, a[7:0]);
    chk(o_port_f_bits, a[15:8]);
    w(1);
    #1 chk(o_port_e_oe, wr ? 8'hff : 8'h00);
    if (wr) chk(o_port_e_bits, i_acc_wdata);
    w(2);
    #1 chk(o_acc_done, 16'h0);
    w(1);
    #1 chk(o_acc_done, 16'h1);
    // the memory model answers with the inverted low address
    if (!wr) chk(o_acc_rdata, {8'h00, ~a[7:0]});
  endtask
  initial begin
    {i_pa_dir, i_pa_lat, i_pa_rt_data, i_pb_dir, i_pb_lat, i_pc_dir,
     i_pc_lat, i_pd_dir, i_pd_lat, i_pe_lat, i_pf_dir, i_pf_lat,
     i_acc_wdata, i_port_a_bits, i_port_b_bits, i_port_c_bits,
     i_port_d_bits, i_port_f_bits, i_pa_rt_en, i_pa_rt_trig, i_pwm,
     i_acc_addr, i_pe_dir, i_mem_exp_en, i_acc_req, i_acc_wr, i_ser_en,
     i_ser_sync, i_ser_clk_out, i_ser_clk, i_ser_txd, i_pwm_en,
     i_psram_refresh_pulse_en, i_mode_select_a} = '0;
    i_external_fetch_select = 1'b0;
    w(10);
    i_rst <= 1'b0;
    w(4);
    #1 chk(o_port_a_oe, 8'h00);
    chk(o_rom_less, 16'h1);
    // direction granularity of each port
    w(1);
    i_pa_dir <= 8'ha5;
    i_pa_lat <= 8'h3c;
    i_pf_dir <= 8'h5a;
    i_pc_dir <= 8'hff;
    i_pd_dir <= 8'hff;
    i_pe_dir <= 1'b1;
    i_pb_dir <= 8'hc3;
    i_pb_lat <= 8'h81;
    i_port_b_bits <= 8'h11;
    i_port_d_bits <= 8'h22;
    i_port_f_bits <= 8'h44;
    w(2);
    #1 chk(o_port_a_oe, 8'ha5);
    chk(o_port_b_oe, 8'hc3);
    chk(o_port_b_bits, 8'h81);
    chk(o_pin_b, 8'h11);
    chk(o_pin_d, 8'h22);
    chk(o_pin_f, 8'h44);
    chk(o_port_a_bits & o_port_a_oe, 8'h24);
    chk(o_port_f_oe, 8'h5a);
    chk(o_port_c_oe, 8'hf0);
    chk(o_port_d_oe, 8'hf0);
    chk(o_port_e_oe, 8'hff);
    w(1);
    i_pe_dir <= 1'b0;
    // real-time nibbles load one at a time
    i_pa_rt_en <= 2'b11;
    i_pa_rt_data <= 8'h5c;
    i_pa_rt_trig <= 2'b01;
    w(1);
    i_pa_rt_trig <= 2'b00;
    w(2);
    #1 chk(o_port_a_bits[3:0], 4'hc);
    chk(o_port_e_oe, 8'h00);
    w(1);
    i_pa_rt_data <= 8'ha3;
    i_pa_rt_trig <= 2'b10;
    w(1);
    i_pa_rt_trig <= 2'b00;
    w(2);
    #1 chk(o_port_a_bits, 8'hac);
    w(1);
    i_pa_rt_en <= 2'b00;
    i_mem_exp_en <= 1'b1;
    i_acc_wdata <= 8'h96;
    w(1);
    acc(1'b1, 16'h12ab);
    w(1);
    acc(1'b0, 16'h34cd);
    w(4);
    #1 chk(o_pin_e, 8'h32);
    // serial handshake pin, both modes, then released
    w(1);
    i_ser_en <= 1'b1;
    i_pc_dir <= 8'h00;
    w(4);
    #1 chk(o_tx_enable, 16'h0);
    chk(o_port_c_oe[4], 1'b1);
    w(1);
    i_port_c_bits <= 8'h80;
    w(4);
    #1 chk(o_tx_enable, 16'h1);
    w(1);
    i_ser_sync <= 1'b1;
    i_ser_clk_out <= 1'b1;
    i_ser_clk <= 1'b1;
    w(2);
    #1 chk(o_port_c_oe[7], 1'b1);
    chk(o_port_c_bits[7], 1'b1);
    w(1);
    i_ser_clk_out <= 1'b0;
    w(4);
    #1 chk(o_ser_clk_in, 16'h1);
    chk(o_port_c_oe[7], 1'b0);
    w(1);
    i_port_c_bits <= 8'h00;
    w(4);
    #1 chk(o_ser_clk_in, 16'h0);
    w(1);
    i_ser_en <= 1'b0;
    w(2);
    #1 chk(o_port_c_oe, 8'h00);
    // pwm takes port d bits 4 and 5 over a port set to input
    w(1);
    i_pwm_en <= 1'b1;
    i_pwm <= 2'b10;
    i_pd_dir <= 8'h00;
    w(2);
    #1 chk(o_port_d_oe, 8'h30);
    chk(o_port_d_bits, 8'h20);
    w(1);
    i_pwm_en <= 1'b0;
    w(2);
    #1 chk(o_port_d_oe, 8'h00);
    // refresh pulses counted over two periods
    w(1);
    i_psram_refresh_pulse_en <= 1'b1;
    n = 0;
    repeat (128) begin
      w(1);
      #1 n += o_psram_refresh_pulse;
    end
    chk(n[15:0], 16'h2);
    // second reset, fetch select pin now high
    w(1);
    i_rst <= 1'b1;
    i_external_fetch_select <= 1'b1;
    w(2);
    #1 chk(o_sys_rst, 16'h1);
    w(8);
    i_rst <= 1'b0;
    w(4);
    #1 chk(o_rom_less, 16'h0);
    // programming mode takes over port a and the reset pin
    w(1);
    i_mode_select_a <= 1'b1;
    i_port_a_bits <= 8'h80;
    w(5);
    #1 chk(o_prom_mode, 16'h1);
    chk({o_prom_oe_n, o_prom_ce_n}, 16'h2);
    chk(o_port_a_oe, 8'h00);
    chk(o_pin_a, 8'h80);
    w(1);
    i_rst <= 1'b1;
    w(2);
    #1 chk(o_sys_rst, 16'h0);
    print_verdict;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge i_mclk);
    err_count++;
    print_verdict;
  end
endmodule
